//--- rtl/mdc_pkg.sv
// Shared constants and types of the multichannel DMA controller.
// Assumes both ends share one clock, pclk, and one reset, presetn.
`default_nettype none
package mdc_pkg;
   localparam int NCH = 14;
   // Register offsets, byte addresses on the register port and APB
   localparam logic [4:0] OFF_CFG = 5'h00;
   localparam logic [4:0] OFF_BASE = 5'h04;
   localparam logic [4:0] OFF_PRISET = 5'h08;
   localparam logic [4:0] OFF_PRICLR = 5'h0c;
   localparam logic [4:0] OFF_SWREQ = 5'h10;
   localparam logic [4:0] OFF_STATUS = 5'h14;
   localparam int CFG_EN_BIT = 0;
   // Reset values
   localparam logic CFG_EN_RST = 1'h0;
   localparam logic [31:0] BASE_RST = 32'h0;
   localparam logic [13:0] PRI_RST = 14'h0;
   // Descriptor layout
   localparam logic [31:0] DESC_SRC = 32'h0;
   localparam logic [31:0] DESC_DST = 32'h4;
   localparam logic [31:0] DESC_CTRL = 32'h8;
   localparam int DESC_SHIFT = 4;
   // Control word fields
   localparam int DINC_LO = 30;
   localparam int DSZ_LO = 28;
   localparam int SINC_LO = 26;
   localparam int SSZ_LO = 24;
   localparam int RPOW_LO = 14;
   localparam int NM1_LO = 4;
   localparam int NM1_W = 10;
   localparam int MODE_LO = 0;
   localparam logic [2:0] MODE_STOP = 3'h0;
   localparam logic [2:0] MODE_BASIC = 3'h1;
   localparam logic [2:0] MODE_AUTO = 3'h2;
   localparam logic [2:0] MODE_PINGPONG = 3'h3;
   localparam logic [1:0] INC_NONE = 2'h3;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_PSRC = 3'h1,
      ST_PDST = 3'h3,
      ST_CTRL = 3'h2,
      ST_READ = 3'h6,
      ST_WRITE = 3'h7,
      ST_WBACK = 3'h5
   } mdc_state_t;
endpackage : mdc_pkg
`default_nettype wire

//--- rtl/mdc_if.sv
// Link between the DMA engine and its system end.
// Assumes the system end joins software, requests and memory to it.
`default_nettype none
interface mdc_if;
   // Register port
   logic reg_sel;
   logic reg_write;
   logic [4:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   // Requests and completions
   logic [mdc_pkg::NCH-1:0] req;
   logic [mdc_pkg::NCH-1:0] done;
   // System bus, engine is master
   logic bus_valid;
   logic bus_write;
   logic [1:0] bus_size;
   logic [31:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   logic bus_ready;
   modport dev (
      input reg_sel, reg_write, reg_addr, reg_wdata, req, bus_rdata, bus_ready,
      output reg_rdata, done, bus_valid, bus_write, bus_size, bus_addr, bus_wdata
   );
   modport sys (
      output reg_sel, reg_write, reg_addr, reg_wdata, req, bus_rdata, bus_ready,
      input reg_rdata, done, bus_valid, bus_write, bus_size, bus_addr, bus_wdata
   );
endinterface : mdc_if
`default_nettype wire

//--- rtl/mdc_host.sv
// System end: APB slave onto the engine's register port, request and
// completion lines, and the shared bus arbiter between processor and engine.
// Assumes a memory slave on the mem_* port answering with mem_ready.
`default_nettype none
module mdc_host (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral requests and completion interrupts
   input wire logic [mdc_pkg::NCH-1:0] periph_req,
   output logic [mdc_pkg::NCH-1:0] dma_irq,
   // Processor bus port
   input wire logic cpu_valid,
   input wire logic cpu_write,
   input wire logic [1:0] cpu_size,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   output logic [31:0] cpu_rdata,
   output logic cpu_ready,
   // Memory bus port
   output logic mem_valid,
   output logic mem_write,
   output logic [1:0] mem_size,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ready,
   // Engine
   mdc_if.sys link
);
   typedef struct packed {
      logic busy;
      logic dma;
   } mdc_host_state_t;

   mdc_host_state_t r_reg;
   mdc_host_state_t r_next;
   logic mapped;
   logic sel_dma;

   always_comb begin
      mapped = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0) && (paddr[4:0] <= mdc_pkg::OFF_STATUS);
      link.reg_sel = psel;
      link.reg_addr = paddr[4:0];
      link.reg_wdata = pwdata;
      // Writes land only at the access edge
      link.reg_write = psel && penable && pwrite && mapped;
      pready = 1'b1;
      pslverr = psel && penable && !mapped;
      prdata = mapped ? link.reg_rdata : 32'h0;
      // Bit n of the request word is channel n's own peripheral line
      link.req = periph_req;
      dma_irq = link.done;
      // Engine wins a free bus; an owner keeps it until its handshake
      sel_dma = r_reg.busy ? r_reg.dma : link.bus_valid;
      mem_valid = sel_dma ? link.bus_valid : cpu_valid;
      mem_write = sel_dma ? link.bus_write : cpu_write;
      mem_size = sel_dma ? link.bus_size : cpu_size;
      mem_addr = sel_dma ? link.bus_addr : cpu_addr;
      mem_wdata = sel_dma ? link.bus_wdata : cpu_wdata;
      cpu_rdata = mem_rdata;
      link.bus_rdata = mem_rdata;
      cpu_ready = !sel_dma && mem_ready;
      link.bus_ready = sel_dma && mem_ready;
      r_next.busy = mem_valid && !mem_ready;
      r_next.dma = sel_dma;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : mdc_host
`default_nettype wire

//--- rtl/mdc_device.sv
// DMA engine: arbiter, descriptor fetch and data mover for all channels.
// Assumes the system end answers bus requests and drives the register port.
// Functional notes
// - Fourteen channels, one request line each
// - Fixed channel to peripheral assignment
// - Software trigger per channel starts service
// - High level beats every default level
// - Same level: lowest channel number wins
// - Priority-set write one raises channel
// - Independent source and destination widths
// - Software aligns addresses to widths
// - Memory and peripheral transfers any direction
// - Masters shared bus, may stall processor
// - Completion line pulses after last transfer
// - Descriptor fetched from memory before data
// - Enabled peripheral raises request when needed
// - Primary and alternate structure per channel
// - Structure: source, destination, control, reserved
// - Pointers hold block end addresses
// - Primary base+n*16, alternate base+0x100+n*16
// - Base pointer register locates all structures
// - Software fills structure before requesting
// - Control word sets widths, count, rearbitration
// - Control word increment and width fields
// - Increment code 11 keeps address fixed
`default_nettype none
module mdc_device (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link to the system end
   mdc_if.dev link
);
   localparam int NCH = mdc_pkg::NCH;

   typedef struct packed {
      mdc_pkg::mdc_state_t st;
      logic en;
      logic [31:0] base;
      logic [NCH-1:0] pri;
      logic [NCH-1:0] pend;
      logic [NCH-1:0] alt;
      logic [NCH-1:0] done;
      logic [3:0] ch;
      logic [31:0] src_end;
      logic [31:0] dst_end;
      logic [31:0] ctrl;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [15:0] cnt;
      logic bvalid;
      logic bwrite;
      logic [1:0] bsize;
   } mdc_dev_state_t;

   mdc_dev_state_t r_reg;
   mdc_dev_state_t r_next;

   // Lowest set index wins
   function automatic logic [3:0] mdc_lowest(input logic [NCH-1:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : mdc_lowest

   // Current address from the end pointer and remaining count
   function automatic logic [31:0] mdc_addr(input logic [31:0] end_ptr, input logic [1:0] inc,
                                            input logic [mdc_pkg::NM1_W-1:0] rem);
      logic [31:0] step;
      step = {22'h0, rem} << inc;
      if (inc == mdc_pkg::INC_NONE) begin
         return end_ptr;
      end
      return end_ptr - step;
   endfunction : mdc_addr

   logic [NCH-1:0] active;
   logic [NCH-1:0] high;
   logic [NCH-1:0] trig;
   logic [NCH-1:0] clr;
   logic [3:0] pick;
   logic [31:0] desc;
   logic [mdc_pkg::NM1_W-1:0] rem;
   logic [2:0] mode;
   logic hs;
   logic last;
   logic still_req;

   always_comb begin
      r_next = r_reg;
      r_next.done = '0;
      trig = '0;
      clr = '0;
      // Requests only count while enabled
      active = (link.req | r_reg.pend) & {NCH{r_reg.en}};
      high = active & r_reg.pri;
      pick = (|high) ? mdc_lowest(high) : mdc_lowest(active);
      desc = r_reg.base + {23'h0, r_reg.alt[r_reg.ch], r_reg.ch, 4'h0};
      rem = r_reg.ctrl[mdc_pkg::NM1_LO +: mdc_pkg::NM1_W];
      mode = r_reg.ctrl[mdc_pkg::MODE_LO +: 3];
      hs = r_reg.bvalid && link.bus_ready;
      last = (rem == '0);
      still_req = link.req[r_reg.ch] || r_reg.pend[r_reg.ch];

      if (link.reg_sel && link.reg_write) begin
         case (link.reg_addr)
            mdc_pkg::OFF_CFG: r_next.en = link.reg_wdata[mdc_pkg::CFG_EN_BIT];
            mdc_pkg::OFF_BASE: r_next.base = link.reg_wdata;
            mdc_pkg::OFF_PRISET: r_next.pri = r_reg.pri | link.reg_wdata[NCH-1:0];
            mdc_pkg::OFF_PRICLR: r_next.pri = r_reg.pri & ~link.reg_wdata[NCH-1:0];
            mdc_pkg::OFF_SWREQ: trig = link.reg_wdata[NCH-1:0];
            default: ;
         endcase
      end
      case (link.reg_addr)
         mdc_pkg::OFF_CFG: r_next.rdata = {31'h0, r_reg.en};
         mdc_pkg::OFF_BASE: r_next.rdata = r_reg.base;
         mdc_pkg::OFF_PRISET: r_next.rdata = {18'h0, r_reg.pri};
         mdc_pkg::OFF_PRICLR: r_next.rdata = {18'h0, r_reg.pri};
         mdc_pkg::OFF_SWREQ: r_next.rdata = {18'h0, r_reg.pend};
         mdc_pkg::OFF_STATUS: r_next.rdata = {9'h0, r_reg.alt, r_reg.ch, 1'b0, r_reg.st, r_reg.st != mdc_pkg::ST_IDLE};
         default: r_next.rdata = 32'h0;
      endcase

      case (r_reg.st)
         mdc_pkg::ST_IDLE: begin
            // Each idle pass is a fresh arbitration round
            if (|active) begin
               r_next.ch = pick;
               r_next.cnt = 16'h0;
               r_next.addr = r_reg.base + {23'h0, r_reg.alt[pick], pick, 4'h0} + mdc_pkg::DESC_SRC;
               r_next.bvalid = 1'b1;
               r_next.bwrite = 1'b0;
               r_next.bsize = mdc_pkg::SZ_WORD;
               r_next.st = mdc_pkg::ST_PSRC;
            end
         end
         mdc_pkg::ST_PSRC: begin
            if (hs) begin
               r_next.src_end = link.bus_rdata;
               r_next.addr = desc + mdc_pkg::DESC_DST;
               r_next.st = mdc_pkg::ST_PDST;
            end
         end
         mdc_pkg::ST_PDST: begin
            if (hs) begin
               r_next.dst_end = link.bus_rdata;
               r_next.addr = desc + mdc_pkg::DESC_CTRL;
               r_next.st = mdc_pkg::ST_CTRL;
            end
         end
         mdc_pkg::ST_CTRL: begin
            if (hs) begin
               r_next.ctrl = link.bus_rdata;
               // A stopped structure drops the trigger rather than spin on it
               if (link.bus_rdata[mdc_pkg::MODE_LO +: 3] == mdc_pkg::MODE_STOP) begin
                  clr[r_reg.ch] = 1'b1;
                  r_next.bvalid = 1'b0;
                  r_next.st = mdc_pkg::ST_IDLE;
               end else begin
                  r_next.addr = mdc_addr(r_reg.src_end, link.bus_rdata[mdc_pkg::SINC_LO +: 2],
                                         link.bus_rdata[mdc_pkg::NM1_LO +: mdc_pkg::NM1_W]);
                  r_next.bsize = link.bus_rdata[mdc_pkg::SSZ_LO +: 2];
                  r_next.st = mdc_pkg::ST_READ;
               end
            end
         end
         mdc_pkg::ST_READ: begin
            if (hs) begin
               r_next.wdata = link.bus_rdata;
               r_next.addr = mdc_addr(r_reg.dst_end, r_reg.ctrl[mdc_pkg::DINC_LO +: 2], rem);
               r_next.bsize = r_reg.ctrl[mdc_pkg::DSZ_LO +: 2];
               r_next.bwrite = 1'b1;
               r_next.st = mdc_pkg::ST_WRITE;
            end
         end
         mdc_pkg::ST_WRITE: begin
            if (hs) begin
               r_next.cnt = r_reg.cnt + 16'h1;
               if (last) begin
                  r_next.ctrl[mdc_pkg::MODE_LO +: 3] = mdc_pkg::MODE_STOP;
               end else begin
                  r_next.ctrl[mdc_pkg::NM1_LO +: mdc_pkg::NM1_W] = rem - 10'h1;
               end
               // Stop at the burst limit, the end, or a dropped basic request
               if (last || (r_reg.cnt + 16'h1 == (16'h1 << r_reg.ctrl[mdc_pkg::RPOW_LO +: 4])) ||
                   (mode == mdc_pkg::MODE_BASIC && !still_req)) begin
                  r_next.wdata = last ? {r_reg.ctrl[31:3], mdc_pkg::MODE_STOP} :
                                 {r_reg.ctrl[31:14], rem - 10'h1, r_reg.ctrl[3:0]};
                  r_next.addr = desc + mdc_pkg::DESC_CTRL;
                  r_next.bsize = mdc_pkg::SZ_WORD;
                  r_next.st = mdc_pkg::ST_WBACK;
               end else begin
                  r_next.addr = mdc_addr(r_reg.src_end, r_reg.ctrl[mdc_pkg::SINC_LO +: 2], rem - 10'h1);
                  r_next.bsize = r_reg.ctrl[mdc_pkg::SSZ_LO +: 2];
                  r_next.bwrite = 1'b0;
                  r_next.st = mdc_pkg::ST_READ;
               end
            end
         end
         mdc_pkg::ST_WBACK: begin
            if (hs) begin
               r_next.bvalid = 1'b0;
               r_next.bwrite = 1'b0;
               r_next.st = mdc_pkg::ST_IDLE;
               if (r_reg.ctrl[mdc_pkg::MODE_LO +: 3] == mdc_pkg::MODE_STOP) begin
                  r_next.done[r_reg.ch] = 1'b1;
                  clr[r_reg.ch] = 1'b1;
                  if (mode == mdc_pkg::MODE_STOP && r_reg.wdata[31:3] == r_reg.ctrl[31:3]) begin
                     r_next.alt[r_reg.ch] = r_reg.alt[r_reg.ch];
                  end
               end
            end
         end
         default: begin
            r_next.bvalid = 1'b0;
            r_next.st = mdc_pkg::ST_IDLE;
         end
      endcase
      // Ping-pong flips to the other structure once one half completes
      if (r_reg.st == mdc_pkg::ST_WRITE && hs && last && mode == mdc_pkg::MODE_PINGPONG) begin
         r_next.alt[r_reg.ch] = !r_reg.alt[r_reg.ch];
      end
      // A trigger landing with the completion clear survives
      r_next.pend = (r_reg.pend & ~clr) | trig;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.en <= mdc_pkg::CFG_EN_RST;
         r_reg.base <= mdc_pkg::BASE_RST;
         r_reg.pri <= mdc_pkg::PRI_RST;
         r_reg.st <= mdc_pkg::ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.reg_rdata = r_reg.rdata;
   assign link.done = r_reg.done;
   assign link.bus_valid = r_reg.bvalid;
   assign link.bus_write = r_reg.bwrite;
   assign link.bus_size = r_reg.bsize;
   assign link.bus_addr = r_reg.addr;
   assign link.bus_wdata = r_reg.wdata;
endmodule : mdc_device
`default_nettype wire

//--- sim/mdc_props.sv
// Assertions on the link between the DMA engine and its system end.
// Assumes one clock, pclk, and an asynchronous active-low reset, presetn.
`default_nettype none
module mdc_props (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register port
   input wire logic reg_write,
   input wire logic [4:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   // Completions and engine bus
   input wire logic [mdc_pkg::NCH-1:0] done,
   input wire logic bus_valid,
   input wire logic bus_write,
   input wire logic [1:0] bus_size,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_ready
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] beats;
   logic [7:0] rd_q;
   logic [31:0] first_q, base_q, off;
   logic en_q, hs, wb, any_done;
   assign hs = bus_valid && bus_ready;
   assign off = bus_addr - base_q;
   assign any_done = |done;
   // Control write-back is the only write to the fetched control address
   assign wb = hs && bus_write && beats >= 8'h03 && bus_addr == first_q + 32'h8;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beats <= 8'h00;
         rd_q <= 8'h00;
         first_q <= 32'h0;
         base_q <= 32'h0;
         en_q <= 1'b0;
      end else begin
         if (!bus_valid) beats <= 8'h00;
         else if (hs && beats != 8'hff) beats <= beats + 8'h01;
         if (bus_valid && beats == 8'h00) first_q <= bus_addr;
         if (hs && !bus_write) rd_q <= bus_rdata[7:0];
         if (reg_write && reg_addr == mdc_pkg::OFF_BASE) base_q <= reg_wdata;
         if (reg_write && reg_addr == mdc_pkg::OFF_CFG) en_q <= reg_wdata[mdc_pkg::CFG_EN_BIT];
      end
   end
   sequence data_read_s;
      hs && !bus_write && beats >= 8'h03;
   endsequence
   sequence wback_s;
      wb;
   endsequence
   bus_hold_a: assert property (bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr)
      && $stable(bus_write) && $stable(bus_wdata) && $stable(bus_size)) else $error("bus request moved early");
   fetch_first_a: assert property ($rose(bus_valid) |-> !bus_write && bus_addr[3:0] == 4'h0)
      else $error("service did not start with a source pointer read");
   desc_place_a: assert property ($rose(bus_valid) |-> off < 32'h1e0 && off[7:0] < 8'he0)
      else $error("descriptor fetched outside the structure area");
   dst_fetch_a: assert property (bus_valid && beats == 8'h01 |-> !bus_write && bus_addr == first_q + 32'h4)
      else $error("destination pointer not read second");
   ctrl_fetch_a: assert property (bus_valid && beats == 8'h02 |-> !bus_write && bus_addr == first_q + 32'h8)
      else $error("control word not read third");
   done_pulse_a: assert property (any_done |=> done == 14'h0) else $error("completion longer than one cycle");
   done_cause_a: assert property ($rose(any_done) |-> $past(wb)) else $error("completion without write-back");
   idle_gap_a: assert property (wback_s |=> !bus_valid) else $error("no idle cycle after write-back");
   pair_a: assert property (data_read_s |=> bus_valid && bus_write && bus_wdata[7:0] == rd_q)
      else $error("read data not written onward");
   enable_gate_a: assert property (!en_q && !bus_valid |=> !bus_valid) else $error("service while disabled");
endmodule : mdc_props
`default_nettype wire

//--- sim/multichannel_dma_controller_tb.sv
// Testbench joining both ends over the link, with a byte-lane memory.
// Assumes the descriptor area at 0x200 and data below 0x200.
`default_nettype none
module multichannel_dma_controller_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] BASE = 32'h200;
   // Word source and destination, both stepping by a word
   localparam logic [31:0] WCW = 32'haa00_0000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
   logic cpu_valid, cpu_write, cpu_ready, mem_valid, mem_write, mem_ready;
   logic [31:0] paddr, pwdata, prdata, cpu_addr, cpu_wdata, cpu_rdata, mem_addr, mem_wdata, mem_rdata, rd;
   logic [13:0] periph_req, dma_irq;
   logic [1:0] cpu_size, mem_size;
   logic [31:0] mem [0:255];
   int num_errors, checked;
   int order[$];
   mdc_if link();
   mdc_host i_mdc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .periph_req(periph_req), .dma_irq(dma_irq), .cpu_valid(cpu_valid), .cpu_write(cpu_write),
      .cpu_size(cpu_size), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_ready(cpu_ready), .mem_valid(mem_valid), .mem_write(mem_write), .mem_size(mem_size),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready), .link(link));
   mdc_device i_mdc_device (.pclk(pclk), .presetn(presetn), .link(link));
   mdc_props i_mdc_props (.pclk(pclk), .presetn(presetn), .reg_write(link.reg_write), .reg_addr(link.reg_addr),
      .reg_wdata(link.reg_wdata), .done(link.done), .bus_valid(link.bus_valid), .bus_write(link.bus_write),
      .bus_size(link.bus_size), .bus_addr(link.bus_addr), .bus_wdata(link.bus_wdata),
      .bus_rdata(link.bus_rdata), .bus_ready(link.bus_ready));
   // Read data right-aligned; writes touch only the lanes of the size
   assign mem_rdata = mem[mem_addr[9:2]] >> {mem_addr[1:0], 3'b000};
   always @(posedge pclk) begin
      mem_ready <= !slow || !mem_ready;
      if (mem_valid && mem_ready && mem_write)
         for (int b = 0; b < 4; b++)
            if (b >= mem_addr[1:0] && b < mem_addr[1:0] + (1 << mem_size))
               mem[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*(b - mem_addr[1:0]) +: 8];
      for (int c = 0; c < 14; c++)
         if (dma_irq[c] === 1'b1) order.push_back(c);
   end
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic timeout(input string what);
      num_errors++;
      $display("MISMATCH at %0t: no answer from %s", $time, what);
      give_verdict();
   endtask : timeout
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {27'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) timeout("register port");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_done(input int k);
      int n;
      n = 0;
      while (order.size() < k && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) timeout("engine");
   endtask : wait_done
   task automatic desc(input int ch, input int alt, input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
      int i;
      i = (BASE + alt * 256 + ch * 16) >> 2;
      mem[i] = s;
      mem[i + 1] = d;
      mem[i + 2] = c;
   endtask : desc
   initial begin
      int chs[3];
      int n;
      chs = '{1, 2, 5};
      {presetn, psel, penable, pwrite, slow, cpu_valid, cpu_write} = 7'h0;
      {paddr, pwdata, cpu_addr, cpu_wdata, cpu_size, periph_req} = '0;
      for (int i = 0; i < 256; i++) mem[i] = 32'ha500_0000 + i;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, mdc_pkg::OFF_CFG, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, mdc_pkg::OFF_PRISET, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 5'h18, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, mdc_pkg::OFF_BASE, BASE);
      apb(1'b0, mdc_pkg::OFF_BASE, 32'h0);
      chk(rd, BASE);
      // Three single-word copies queued while disabled, channel 5 raised
      foreach (chs[k]) desc(chs[k], 0, chs[k] * 16, 32'h100 + chs[k] * 16, WCW | 32'h1);
      apb(1'b1, mdc_pkg::OFF_SWREQ, 32'h26);
      apb(1'b1, mdc_pkg::OFF_PRISET, 32'h20);
      repeat (20) @(posedge pclk);
      chk(order.size(), 32'h0);
      apb(1'b0, mdc_pkg::OFF_PRISET, 32'h0);
      chk(rd, 32'h20);
      apb(1'b1, mdc_pkg::OFF_CFG, 32'h1);
      wait_done(3);
      chk(order[0], 32'h5);
      chk(order[1], 32'h1);
      chk(order[2], 32'h2);
      foreach (chs[k]) chk(mem[64 + chs[k] * 4], 32'ha500_0000 + chs[k] * 4);
      foreach (chs[k]) chk(mem[128 + chs[k] * 4 + 2] & 32'h7, 32'h0);
      apb(1'b1, mdc_pkg::OFF_PRICLR, 32'h20);
      apb(1'b0, mdc_pkg::OFF_PRICLR, 32'h0);
      chk(rd, 32'h0);
      // Four words on a hardware request, bursts of two, slow memory, processor contending
      desc(3, 0, 32'h3c, 32'h13c, WCW | 32'h4031);
      slow <= 1'b1;
      periph_req <= 14'h0008;
      repeat (4) @(posedge pclk);
      cpu_valid <= 1'b1;
      cpu_addr <= 32'h3f0;
      cpu_size <= mdc_pkg::SZ_WORD;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (cpu_ready !== 1'b1 && n < 500);
      if (n >= 500) timeout("processor port");
      rd = cpu_rdata;
      cpu_valid <= 1'b0;
      chk(rd, 32'ha500_00fc);
      wait_done(4);
      periph_req <= 14'h0;
      slow <= 1'b0;
      for (int i = 0; i < 4; i++) chk(mem[76 + i], 32'ha500_000c + i);
      // Fixed word source into a byte destination on the last channel
      mem[36] = 32'h1234_56c3;
      desc(13, 0, 32'h90, 32'h193, 32'h0e00_c031);
      periph_req <= 14'h2000;
      wait_done(5);
      periph_req <= 14'h0;
      chk(mem[100], 32'hc3c3_c3c3);
      // Ping-pong on the primary structure, then the alternate one
      desc(0, 0, 32'h60, 32'h160, WCW | 32'h3);
      desc(0, 1, 32'h70, 32'h170, WCW | 32'h1);
      apb(1'b1, mdc_pkg::OFF_SWREQ, 32'h1);
      wait_done(6);
      apb(1'b0, mdc_pkg::OFF_STATUS, 32'h0);
      chk({31'h0, rd[9]}, 32'h1);
      apb(1'b1, mdc_pkg::OFF_SWREQ, 32'h1);
      wait_done(7);
      chk(mem[88], 32'ha500_0018);
      chk(mem[92], 32'ha500_001c);
      give_verdict();
   end
endmodule : multichannel_dma_controller_tb
`default_nettype wire
